/* File: gauge_core_properties.sv */
/*
  Port checker for the gas gauge core: init, display, pins, reply.
  Bound to the core below; checks pause while CLK_EN is low.
*/
module gauge_core_checker #(
  parameter int unsigned SHORT_CYCLES = 4000,
  parameter int unsigned LONG_CYCLES = 13000
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic DISPLAY_DISABLE_INPUT,
  input wire logic STRAP_PULLUP_EN,
  input wire logic STRAP_PULLDOWN_EN,
  input wire logic [4:0] LED_SEGMENT_OUTPUTS_O,
  input wire logic [4:0] LED_SEGMENT_OUTPUTS_OE_N,
  input wire logic LED_COMMON_DRIVE_OE_N,
  input wire logic CONTROL_PORT_OUTPUT_O,
  input wire logic SINGLE_WIRE_PORT_O,
  input wire logic SINGLE_WIRE_PORT_OE_N
);
  logic [10:0] init_cnt_ff;
  logic [15:0] low_cnt_ff;
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST || !CLK_EN);
  // Saturates well past the end of strap reading
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      init_cnt_ff <= '0;
    else if (CLK_EN && init_cnt_ff != 11'h7ff)
      init_cnt_ff <= init_cnt_ff + 11'h1;
  end
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST || SINGLE_WIRE_PORT_OE_N)
      low_cnt_ff <= '0;
    else
      low_cnt_ff <= low_cnt_ff + 16'h1;
  end
  a_common_init_off: assert property (
    init_cnt_ff < 11'd1990 |->
    LED_COMMON_DRIVE_OE_N && &LED_SEGMENT_OUTPUTS_OE_N)
    else $error("LED drive active during strap reading");
  a_display_off: assert property (
    DISPLAY_DISABLE_INPUT |=> LED_COMMON_DRIVE_OE_N)
    else $error("LED common not released with display off");
  a_display_on: assert property (
    init_cnt_ff == 11'h7ff && !DISPLAY_DISABLE_INPUT
    |=> !LED_COMMON_DRIVE_OE_N)
    else $error("LED common not switched on");
  a_pins_sink: assert property (
    LED_SEGMENT_OUTPUTS_O == 5'h00 && !SINGLE_WIRE_PORT_O
    && !CONTROL_PORT_OUTPUT_O)
    else $error("Open-drain pin driven high");
  a_pullup_phase: assert property (
    init_cnt_ff inside {[10:990]} |->
    STRAP_PULLUP_EN && !STRAP_PULLDOWN_EN)
    else $error("Strap pull-up phase wrong");
  a_pulldown_phase: assert property (
    init_cnt_ff inside {[1010:1990]} |->
    STRAP_PULLDOWN_EN && !STRAP_PULLUP_EN)
    else $error("Strap pull-down phase wrong");
  a_reply_pulse: assert property (
    $rose(SINGLE_WIRE_PORT_OE_N) |->
    low_cnt_ff == SHORT_CYCLES || low_cnt_ff == LONG_CYCLES)
    else $error("Reply pulse length wrong");
  a_reply_gap: assert property (
    $rose(SINGLE_WIRE_PORT_OE_N) |-> SINGLE_WIRE_PORT_OE_N [*8])
    else $error("Reply slot released too briefly");
endmodule

bind primary_cell_gas_gauge_core gauge_core_checker #(
  .SHORT_CYCLES(SHORT_CYCLES),
  .LONG_CYCLES(LONG_CYCLES)
) chk_u (
  .REF_CLK(REF_CLK),
  .SYS_RST(SYS_RST),
  .CLK_EN(CLK_EN),
  .DISPLAY_DISABLE_INPUT(DISPLAY_DISABLE_INPUT),
  .STRAP_PULLUP_EN(STRAP_PULLUP_EN),
  .STRAP_PULLDOWN_EN(STRAP_PULLDOWN_EN),
  .LED_SEGMENT_OUTPUTS_O(LED_SEGMENT_OUTPUTS_O),
  .LED_SEGMENT_OUTPUTS_OE_N(LED_SEGMENT_OUTPUTS_OE_N),
  .LED_COMMON_DRIVE_OE_N(LED_COMMON_DRIVE_OE_N),
  .CONTROL_PORT_OUTPUT_O(CONTROL_PORT_OUTPUT_O),
  .SINGLE_WIRE_PORT_O(SINGLE_WIRE_PORT_O),
  .SINGLE_WIRE_PORT_OE_N(SINGLE_WIRE_PORT_OE_N)
);

/* File: gauge_host_model.sv */
/*
  Host model for the single-wire register port.
  Assumes a pull-up on the line and the core's clock.
*/
module gauge_host_model #(
  parameter int unsigned BIT_CYCLES = 60,
  parameter int unsigned THRESH_CYCLES = 25,
  parameter int unsigned SHORT_CYCLES = 10,
  parameter int unsigned LONG_CYCLES = 40
) (
  input wire logic clk,
  input wire logic dev_oe_n,
  output logic line,
  output logic [7:0] rd_byte,
  output logic rd_vld,
  output logic tmo
);
  logic pull = 1'b0;
  // Pull-up wins unless a party sinks the line
  assign line = !pull && dev_oe_n;
  initial
  begin
    rd_vld = 1'b0;
    tmo = 1'b0;
    rd_byte = 8'h00;
  end
  task automatic send_byte(input logic [7:0] b);
    int n;
    for (int i = 0; i < 8; i++)
    begin
      n = b[i] ? SHORT_CYCLES : LONG_CYCLES;
      @(negedge clk);
      pull = 1'b1;
      repeat (n) @(negedge clk);
      pull = 1'b0;
      repeat (BIT_CYCLES - n) @(negedge clk);
    end
  endtask
  task automatic get_byte();
    int n;
    for (int i = 0; i < 8; i++)
    begin
      n = 0;
      while (line && n < 4 * BIT_CYCLES)
      begin
        @(negedge clk);
        n++;
      end
      tmo = tmo | line;
      n = 0;
      while (!line && n < 2 * LONG_CYCLES)
      begin
        @(negedge clk);
        n++;
      end
      rd_byte[i] = n < THRESH_CYCLES;
    end
    rd_vld = 1'b1;
    @(negedge clk);
    rd_vld = 1'b0;
    // Next command only after the reply slot is over
    repeat (BIT_CYCLES) @(negedge clk);
  endtask
endmodule

/* File: gauge_pkg.sv */
/*
  Shared constants for the primary-cell gas gauge core: register map,
  flag positions, reset values, strap levels and timing counts.
  Assumes a 100 MHz reference clock.
*/
package gauge_pkg;
  typedef enum logic [1:0] {LVL_H, LVL_Z, LVL_L} strap_lvl_t;

  localparam logic [6:0] ADDR_COMMAND = 7'h00;
  localparam logic [6:0] ADDR_PRIMARY_FLAGS = 7'h01;
  localparam logic [6:0] ADDR_TEMPERATURE = 7'h02;
  localparam logic [6:0] ADDR_BATTERY_VOLTAGE = 7'h0b;
  localparam logic [6:0] ADDR_THRESHOLD = 7'h0c;
  localparam logic [6:0] ADDR_CAPACITY_LOW = 7'h0e;
  localparam logic [6:0] ADDR_CAPACITY_HIGH = 7'h0f;
  localparam logic [6:0] ADDR_DISCHARGE_LOW = 7'h2e;
  localparam logic [6:0] ADDR_DISCHARGE_HIGH = 7'h2f;

  localparam int FLAG_INIT_BIT = 7;
  localparam int FLAG_CTL_PORT_BIT = 4;
  localparam int FLAG_FIRST_EMPTY_BIT = 1;
  localparam int FLAG_FINAL_EMPTY_BIT = 0;
  localparam int CMD_WRITE_BIT = 7;

  // Battery reading is 4 mV per code: 0.76 V and a 0.10 V step
  localparam logic [7:0] THRESHOLD_RESET = 8'hbe;
  localparam logic [7:0] FINAL_STEP = 8'h19;
  localparam logic [3:0] EMPTY_SAMPLES = 4'h8;

  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned QUAL_MS = 4000;
  localparam int unsigned SAMPLE_MS = QUAL_MS / 8;
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_MS * 1000 * CLK_MHZ;
  localparam int unsigned SETTLE_US = 10;
  localparam int unsigned SETTLE_CYCLES = SETTLE_US * CLK_MHZ;

  localparam int signed MIN_DISCHARGE_UV = 250;
  // 3.125 uVh per fundamental count, in uV times sample periods
  localparam int unsigned FUND_NVH = 3125;
  localparam int unsigned FUND_PER_SAMPLE =
    FUND_NVH * 36 / 10 * 1000 / SAMPLE_MS;
  localparam logic [3:0] SCALE_FUND_H = 4'h8;
  localparam logic [3:0] SCALE_FUND_Z = 4'h4;
  localparam logic [3:0] SCALE_FUND_L = 4'h2;

  // Indexed by first strap times three plus second, H Z L order
  localparam logic [15:0] FULL_COUNT_TABLE [0:8] = '{
    16'hbc00, 16'hb400, 16'ha900, 16'h9c00, 16'h9600,
    16'h8d00, 16'h7c00, 16'h7100, 16'h6600};

  localparam logic [7:0] EFF_H = 8'h66;
  localparam logic [7:0] EFF_Z = 8'h62;
  localparam logic [7:0] EFF_L = 8'h5f;
  localparam logic [7:0] EFF_COLD_DROP = 8'h05;
  localparam logic [7:0] EFF_UNITY = 8'h64;

  localparam logic [2:0] SEGS_H = 3'h4;
  localparam logic [2:0] SEGS_Z = 3'h5;
  localparam logic [2:0] SEGS_L = 3'h2;

  localparam int unsigned BIT_US = 190;
  localparam int unsigned THRESH_US = 80;
  localparam int unsigned SHORT_US = 40;
  localparam int unsigned LONG_US = 130;
  localparam int unsigned TURN_US = 200;
  localparam int unsigned IDLE_US = 500;
  localparam int unsigned BIT_CYCLES = BIT_US * CLK_MHZ;
  localparam int unsigned THRESH_CYCLES = THRESH_US * CLK_MHZ;
  localparam int unsigned SHORT_CYCLES = SHORT_US * CLK_MHZ;
  localparam int unsigned LONG_CYCLES = LONG_US * CLK_MHZ;
  localparam int unsigned TURN_CYCLES = TURN_US * CLK_MHZ;
  localparam int unsigned IDLE_CYCLES = IDLE_US * CLK_MHZ;
endpackage

/* File: primary_cell_gas_gauge_core.sv */
/*
  Digital core of a primary-lithium gas gauge: discharge integration,
  empty detection, strap decode, capacity, LED bar and register port.
  Assumes digitised sense, battery and temperature inputs synchronous
  to REF_CLK, and a host on the open-drain single-wire port.
*/
module primary_cell_gas_gauge_core #(
  parameter int unsigned SAMPLE_CYCLES = gauge_pkg::SAMPLE_CYCLES,
  parameter int unsigned BIT_CYCLES = gauge_pkg::BIT_CYCLES,
  parameter int unsigned THRESH_CYCLES = gauge_pkg::THRESH_CYCLES,
  parameter int unsigned SHORT_CYCLES = gauge_pkg::SHORT_CYCLES,
  parameter int unsigned LONG_CYCLES = gauge_pkg::LONG_CYCLES,
  parameter int unsigned TURN_CYCLES = gauge_pkg::TURN_CYCLES,
  parameter int unsigned IDLE_CYCLES = gauge_pkg::IDLE_CYCLES,
  parameter int signed SENSE_OFFSET_UV = 0
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic signed [19:0] SENSE_RESISTOR_INPUT,
  input wire logic [7:0] BATTERY_SENSE_INPUT,
  input wire logic [7:0] TEMPERATURE_INPUT,
  input wire logic DISPLAY_DISABLE_INPUT,
  input wire logic [5:0] STRAP_INPUT,
  output logic STRAP_PULLUP_EN,
  output logic STRAP_PULLDOWN_EN,
  output logic [4:0] LED_SEGMENT_OUTPUTS_O,
  output logic [4:0] LED_SEGMENT_OUTPUTS_OE_N,
  output logic LED_COMMON_DRIVE_O,
  output logic LED_COMMON_DRIVE_OE_N,
  output logic CONTROL_PORT_OUTPUT_O,
  output logic CONTROL_PORT_OUTPUT_OE_N,
  input wire logic SINGLE_WIRE_PORT_I,
  output logic SINGLE_WIRE_PORT_O,
  output logic SINGLE_WIRE_PORT_OE_N
);
  localparam int TW = 26;
  typedef enum logic [1:0] {PH_PULLUP, PH_PULLDOWN, PH_RUN} phase_t;
  typedef struct packed {
    phase_t phase;
    logic [15:0] settle;
    logic [5:0] pu_seen;
    gauge_pkg::strap_lvl_t [5:0] strap;
    logic [TW-1:0] tick;
    logic [31:0] acc;
    logic [3:0] fund;
    logic [15:0] dis_count;
    logic [15:0] full_ref;
    logic [15:0] comp_cap;
    logic [7:0] volts;
    logic [7:0] temperature;
    logic [7:0] thr_first;
    logic [3:0] first_run;
    logic [3:0] final_run;
    logic first_empty;
    logic final_empty;
    logic ctl_port;
    logic init_done;
    logic pull_up;
    logic pull_down;
    logic [4:0] seg_oe_n;
    logic common_oe_n;
    logic drive_hi;
    logic drive_lo;
  } state_t;

  state_t s_ff;
  state_t nxt_s;
  logic [6:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [15:0] full_count;
  logic [3:0] scale_fund;
  logic [2:0] seg_count;
  logic [7:0] eff;
  logic [4:0] lit;
  logic display_on;

  assign STRAP_PULLUP_EN = s_ff.pull_up;
  assign STRAP_PULLDOWN_EN = s_ff.pull_down;
  assign LED_SEGMENT_OUTPUTS_O = {5{s_ff.drive_lo}};
  assign LED_SEGMENT_OUTPUTS_OE_N = s_ff.seg_oe_n;
  assign LED_COMMON_DRIVE_O = s_ff.drive_hi;
  assign LED_COMMON_DRIVE_OE_N = s_ff.common_oe_n;
  assign CONTROL_PORT_OUTPUT_O = s_ff.drive_lo;
  assign CONTROL_PORT_OUTPUT_OE_N = s_ff.ctl_port;
  assign SINGLE_WIRE_PORT_O = s_ff.drive_lo;

  function automatic logic [15:0] full_of(
    input gauge_pkg::strap_lvl_t a,
    input gauge_pkg::strap_lvl_t b
  );
    full_of = gauge_pkg::FULL_COUNT_TABLE[int'(a) * 3 + int'(b)];
  endfunction

  // Configuration decode from latched straps, plus the cold drop on eff from latched temperature
  always_comb
  begin
    full_count = full_of(s_ff.strap[0], s_ff.strap[1]);
    case (s_ff.strap[2])
      gauge_pkg::LVL_H: scale_fund = gauge_pkg::SCALE_FUND_H;
      gauge_pkg::LVL_Z: scale_fund = gauge_pkg::SCALE_FUND_Z;
      default: scale_fund = gauge_pkg::SCALE_FUND_L;
    endcase
    case (s_ff.strap[3])
      gauge_pkg::LVL_H: eff = gauge_pkg::EFF_H;
      gauge_pkg::LVL_Z: eff = gauge_pkg::EFF_Z;
      default: eff = gauge_pkg::EFF_L;
    endcase
    // Below zero degrees the cell delivers less
    if (s_ff.temperature[7])
    begin
      eff = eff - gauge_pkg::EFF_COLD_DROP;
    end
    case (s_ff.strap[4])
      gauge_pkg::LVL_H: seg_count = gauge_pkg::SEGS_H;
      gauge_pkg::LVL_Z: seg_count = gauge_pkg::SEGS_Z;
      default: seg_count = gauge_pkg::SEGS_L;
    endcase
  end

  // Display only while the button holds the input low
  assign display_on = s_ff.init_done && !DISPLAY_DISABLE_INPUT;

  genvar k;
  generate
    for (k = 0; k < 5; k++)
    begin : g_seg
      logic [18:0] have;
      logic [18:0] need;
      assign have = 19'(s_ff.comp_cap) * 19'(seg_count);
      assign need = 19'(full_count) * 19'(k);
      assign lit[k] = display_on && (3'(k) < seg_count) && (have > need);
    end
  endgenerate

  always_comb
  begin
    case (reg_addr)
      gauge_pkg::ADDR_PRIMARY_FLAGS:
      begin
        reg_rdata = '0;
        reg_rdata[gauge_pkg::FLAG_INIT_BIT] = s_ff.init_done;
        reg_rdata[gauge_pkg::FLAG_CTL_PORT_BIT] = s_ff.ctl_port;
        reg_rdata[gauge_pkg::FLAG_FIRST_EMPTY_BIT] = s_ff.first_empty;
        reg_rdata[gauge_pkg::FLAG_FINAL_EMPTY_BIT] = s_ff.final_empty;
      end
      gauge_pkg::ADDR_TEMPERATURE: reg_rdata = s_ff.temperature;
      gauge_pkg::ADDR_BATTERY_VOLTAGE: reg_rdata = s_ff.volts;
      gauge_pkg::ADDR_THRESHOLD: reg_rdata = s_ff.thr_first;
      gauge_pkg::ADDR_CAPACITY_LOW: reg_rdata = s_ff.comp_cap[7:0];
      gauge_pkg::ADDR_CAPACITY_HIGH: reg_rdata = s_ff.comp_cap[15:8];
      gauge_pkg::ADDR_DISCHARGE_LOW: reg_rdata = s_ff.dis_count[7:0];
      gauge_pkg::ADDR_DISCHARGE_HIGH: reg_rdata = s_ff.dis_count[15:8];
      default: reg_rdata = '0;
    endcase
  end

  always_comb
  begin
    logic signed [21:0] eff_uv;
    logic [23:0] prod;
    logic [15:0] scaled;
    logic [7:0] thr_final;
    logic pd;
    nxt_s = s_ff;
    eff_uv = 22'(SENSE_RESISTOR_INPUT) + 22'(SENSE_OFFSET_UV);
    prod = 24'(s_ff.full_ref) * 24'(eff);
    scaled = 16'(prod / 24'(gauge_pkg::EFF_UNITY));
    thr_final = s_ff.thr_first - gauge_pkg::FINAL_STEP;
    pd = 1'b0;
    case (s_ff.phase)
      PH_PULLUP:
      begin
        // Segments and common released so the straps can be probed
        nxt_s.seg_oe_n = '1;
        nxt_s.common_oe_n = 1'b1;
        nxt_s.settle = s_ff.settle + 1'b1;
        if (s_ff.settle == 16'(gauge_pkg::SETTLE_CYCLES - 1))
        begin
          nxt_s.pu_seen = STRAP_INPUT;
          nxt_s.settle = '0;
          nxt_s.pull_up = 1'b0;
          nxt_s.pull_down = 1'b1;
          nxt_s.phase = PH_PULLDOWN;
        end
      end
      PH_PULLDOWN:
      begin
        nxt_s.settle = s_ff.settle + 1'b1;
        if (s_ff.settle == 16'(gauge_pkg::SETTLE_CYCLES - 1))
        begin
          for (int i = 0; i < 6; i++)
          begin
            // Follows both pulls: floating; holds either: driven
            pd = STRAP_INPUT[i];
            if (s_ff.pu_seen[i] && pd)
              nxt_s.strap[i] = gauge_pkg::LVL_H;
            else if (!s_ff.pu_seen[i] && !pd)
              nxt_s.strap[i] = gauge_pkg::LVL_L;
            else
              nxt_s.strap[i] = gauge_pkg::LVL_Z;
          end
          nxt_s.full_ref = (nxt_s.strap[5] == gauge_pkg::LVL_H) ?
            full_of(nxt_s.strap[0], nxt_s.strap[1]) : '0;
          nxt_s.pull_down = 1'b0;
          nxt_s.init_done = 1'b1;
          nxt_s.phase = PH_RUN;
        end
      end
      PH_RUN:
      begin
        nxt_s.tick = s_ff.tick + 1'b1;
        if (s_ff.tick == TW'(SAMPLE_CYCLES - 1))
        begin
          nxt_s.tick = '0;
          if (eff_uv >= 22'(gauge_pkg::MIN_DISCHARGE_UV))
          begin
            nxt_s.acc = s_ff.acc + 32'(eff_uv);
          end
          nxt_s.volts = BATTERY_SENSE_INPUT;
          nxt_s.temperature = TEMPERATURE_INPUT;
          if (BATTERY_SENSE_INPUT < s_ff.thr_first)
            nxt_s.first_run = (s_ff.first_run == gauge_pkg::EMPTY_SAMPLES) ?
              s_ff.first_run : s_ff.first_run + 1'b1;
          else
            nxt_s.first_run = '0;
          if (BATTERY_SENSE_INPUT < thr_final)
            nxt_s.final_run = (s_ff.final_run == gauge_pkg::EMPTY_SAMPLES) ?
              s_ff.final_run : s_ff.final_run + 1'b1;
          else
            nxt_s.final_run = '0;
        end
        else if (s_ff.acc >= 32'(gauge_pkg::FUND_PER_SAMPLE))
        begin
          // Drain one fundamental count per cycle between samples
          nxt_s.acc = s_ff.acc - 32'(gauge_pkg::FUND_PER_SAMPLE);
          nxt_s.fund = s_ff.fund + 1'b1;
          if (s_ff.fund + 1'b1 >= scale_fund)
          begin
            nxt_s.fund = '0;
            if (s_ff.dis_count != 16'hffff)
              nxt_s.dis_count = s_ff.dis_count + 1'b1;
          end
        end
        // Flags only ever set here; nothing clears them short of reset
        if (nxt_s.first_run == gauge_pkg::EMPTY_SAMPLES)
          nxt_s.first_empty = 1'b1;
        if (nxt_s.final_run == gauge_pkg::EMPTY_SAMPLES)
          nxt_s.final_empty = 1'b1;
        nxt_s.comp_cap = (scaled > s_ff.dis_count) ?
          scaled - s_ff.dis_count : '0;
        nxt_s.seg_oe_n = ~lit;
        nxt_s.common_oe_n = ~display_on;
        // Host writes override any same-cycle count update
        if (reg_wr)
        begin
          case (reg_addr)
            gauge_pkg::ADDR_COMMAND:
              nxt_s.ctl_port = reg_wdata[gauge_pkg::FLAG_CTL_PORT_BIT];
            gauge_pkg::ADDR_THRESHOLD:
              nxt_s.thr_first = reg_wdata;
            gauge_pkg::ADDR_DISCHARGE_LOW:
              nxt_s.dis_count[7:0] = reg_wdata;
            gauge_pkg::ADDR_DISCHARGE_HIGH:
              nxt_s.dis_count[15:8] = reg_wdata;
            default:
              nxt_s.ctl_port = s_ff.ctl_port;
          endcase
        end
      end
      default:
      begin
        nxt_s.phase = PH_PULLUP;
      end
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      s_ff <= '0;
      s_ff.thr_first <= gauge_pkg::THRESHOLD_RESET;
      s_ff.pull_up <= 1'b1;
      s_ff.seg_oe_n <= '1;
      s_ff.common_oe_n <= 1'b1;
      s_ff.ctl_port <= 1'b1;
      s_ff.drive_hi <= 1'b1;
    end
    else if (CLK_EN)
    begin
      s_ff <= nxt_s;
    end
  end

  single_wire_engine #(
    .BIT_CYCLES(BIT_CYCLES),
    .THRESH_CYCLES(THRESH_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES),
    .LONG_CYCLES(LONG_CYCLES),
    .TURN_CYCLES(TURN_CYCLES),
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_port (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .line_i(SINGLE_WIRE_PORT_I),
    .line_oe_n(SINGLE_WIRE_PORT_OE_N),
    .addr(reg_addr),
    .wr_stb(reg_wr),
    .wr_data(reg_wdata),
    .rd_data(reg_rdata)
  );
endmodule

/* File: primary_cell_gas_gauge_core_test.sv */
/*
  Self-checking bench for the gas gauge core.
  Assumes the host model and checker files compile first.
*/
module primary_cell_gas_gauge_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SAMPLE_C = 200;
  localparam int unsigned BIT_C = 60;
  localparam int unsigned THRESH_C = 25;
  localparam int unsigned SHORT_C = 10;
  localparam int unsigned LONG_C = 40;
  localparam int unsigned TURN_C = 60;
  localparam int unsigned IDLE_C = 200;
  logic ref_clk = 1'b0;
  logic clk_en = 1'b1;
  logic [4:0] seg_o;
  logic com_o, ctl_o, sw_o;
  logic sys_rst = 1'b1;
  logic display_disable_input = 1'b1;
  logic signed [19:0] sense = 20'sd249;
  logic [7:0] bat = 8'hff;
  logic [7:0] temp = 8'h10;
  logic [7:0] rd_byte, v;
  logic [5:0] strap;
  logic pu, pd, com_oe_n, ctl_oe_n, sw_oe_n, line, rd_vld, tmo;
  logic [4:0] seg_oe_n;
  logic [7:0] exp_q[$];
  logic [15:0] cap;
  int miscompares = 0;
  int checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  // Straps 0..5: Z H H Z Z H; a floating strap follows the weak pull
  assign strap = {1'b1, pu, pu, 1'b1, 1'b1, pu};
  primary_cell_gas_gauge_core #(.SAMPLE_CYCLES(SAMPLE_C),
    .BIT_CYCLES(BIT_C), .THRESH_CYCLES(THRESH_C),
    .SHORT_CYCLES(SHORT_C), .LONG_CYCLES(LONG_C),
    .TURN_CYCLES(TURN_C), .IDLE_CYCLES(IDLE_C)) dut_u (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en),
    .SENSE_RESISTOR_INPUT(sense), .BATTERY_SENSE_INPUT(bat),
    .TEMPERATURE_INPUT(temp), .DISPLAY_DISABLE_INPUT(display_disable_input),
    .STRAP_INPUT(strap), .STRAP_PULLUP_EN(pu), .STRAP_PULLDOWN_EN(pd),
    .LED_SEGMENT_OUTPUTS_O(seg_o), .LED_SEGMENT_OUTPUTS_OE_N(seg_oe_n),
    .LED_COMMON_DRIVE_O(com_o), .LED_COMMON_DRIVE_OE_N(com_oe_n),
    .CONTROL_PORT_OUTPUT_O(ctl_o), .CONTROL_PORT_OUTPUT_OE_N(ctl_oe_n),
    .SINGLE_WIRE_PORT_I(line), .SINGLE_WIRE_PORT_O(sw_o),
    .SINGLE_WIRE_PORT_OE_N(sw_oe_n));
  gauge_host_model #(.BIT_CYCLES(BIT_C), .THRESH_CYCLES(THRESH_C),
    .SHORT_CYCLES(SHORT_C), .LONG_CYCLES(LONG_C)) host_u (
    .clk(ref_clk), .dev_oe_n(sw_oe_n),
    .line(line), .rd_byte(rd_byte), .rd_vld(rd_vld), .tmo(tmo));
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.send_byte({1'b0, a});
    host_u.get_byte();
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.send_byte({1'b1, a});
    host_u.send_byte(d);
    repeat (60) @(negedge ref_clk);
  endtask
  always @(posedge ref_clk)
  begin
    if (rd_vld === 1'b1)
      chk("register", exp_q.pop_front(), rd_byte);
  end
  always @(posedge tmo)
  begin
    miscompares++;
    test_done();
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end
  initial
  begin
    void'($urandom(94));
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (2100) @(negedge ref_clk);
    cap = 16'(32'(gauge_pkg::FULL_COUNT_TABLE[3]) * gauge_pkg::EFF_Z
      / gauge_pkg::EFF_UNITY);
    rd(7'h01, 8'h90);
    rd(7'h0e, cap[7:0]);
    rd(7'h0f, cap[15:8]);
    v = 8'($urandom);
    bat = 8'hc0 | {2'b00, v[5:0]};
    temp = {2'b00, v[7:2]};
    repeat (400) @(negedge ref_clk);
    rd(7'h0b, bat);
    rd(7'h02, temp);
    v = 8'($urandom);
    wr(7'h2e, v);
    wr(7'h2f, 8'h00);
    // 249 uV must never count, however long it lasts
    repeat (800) @(negedge ref_clk);
    rd(7'h2e, v);
    cap = cap - {8'h00, v};
    rd(7'h0e, cap[7:0]);
    // Eight fundamentals per sample give one count per sample on scale H
    sense = 20'sd180000;
    repeat (800) @(negedge ref_clk);
    sense = 20'sd249;
    rd(7'h2e, v + 8'h04);
    wr(7'h00, 8'h00);
    chk("control port", 8'h00, {7'h00, ctl_oe_n});
    chk("pin levels", 8'h01, {seg_o, ctl_o, sw_o, com_o});
    rd(7'h01, 8'h80);
    wr(7'h00, 8'h10);
    // Frozen core must not follow the button
    clk_en = 1'b0;
    display_disable_input = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("frozen common", 8'h01, {7'h00, com_oe_n});
    clk_en = 1'b1;
    @(negedge ref_clk);
    chk("common", 8'h00, {7'h00, com_oe_n});
    chk("segments", 8'h00, {3'h0, seg_oe_n});
    display_disable_input = 1'b1;
    @(negedge ref_clk);
    chk("common", 8'h01, {7'h00, com_oe_n});
    bat = 8'hbd;
    repeat (1900) @(negedge ref_clk);
    rd(7'h01, 8'h92);
    bat = 8'hff;
    repeat (400) @(negedge ref_clk);
    rd(7'h01, 8'h92);
    bat = 8'ha4;
    repeat (1900) @(negedge ref_clk);
    rd(7'h01, 8'h93);
    sys_rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (2100) @(negedge ref_clk);
    rd(7'h01, 8'h90);
    test_done();
  end
endmodule

/* File: single_wire_engine.sv */
/*
  Byte engine for the open-drain single-wire port: takes a command
  byte, then either a write data byte or sends a read byte back.
  Assumes the line input is already synchronous to the clock.
*/
module single_wire_engine #(
  parameter int unsigned BIT_CYCLES = 19000,
  parameter int unsigned THRESH_CYCLES = 8000,
  parameter int unsigned SHORT_CYCLES = 4000,
  parameter int unsigned LONG_CYCLES = 13000,
  parameter int unsigned TURN_CYCLES = 20000,
  parameter int unsigned IDLE_CYCLES = 50000,
  parameter int unsigned CW = 17
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic line_i,
  output logic line_oe_n,
  output logic [6:0] addr,
  output logic wr_stb,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  typedef enum logic [2:0] {RX_CMD, RX_DATA, TURN, TX_LOW, TX_HIGH} st_t;
  typedef struct packed {
    st_t st;
    logic [CW-1:0] cnt;
    logic low;
    logic [2:0] bits;
    logic [7:0] shreg;
    logic [6:0] addr;
    logic wr_stb;
    logic oe_n;
  } eng_t;

  eng_t e_ff;
  eng_t nxt_e;
  logic [7:0] byte_in;

  assign line_oe_n = e_ff.oe_n;
  assign addr = e_ff.addr;
  assign wr_stb = e_ff.wr_stb;
  assign wr_data = e_ff.shreg;

  always_comb
  begin
    nxt_e = e_ff;
    nxt_e.wr_stb = 1'b0;
    byte_in = {e_ff.cnt < CW'(THRESH_CYCLES), e_ff.shreg[7:1]};
    case (e_ff.st)
      RX_CMD, RX_DATA:
      begin
        if (!line_i)
        begin
          nxt_e.low = 1'b1;
          nxt_e.cnt = e_ff.low ? e_ff.cnt + 1'b1 : '0;
        end
        else if (e_ff.low)
        begin
          // Short low pulse reads as one, long as zero, lsb first
          nxt_e.low = 1'b0;
          nxt_e.cnt = '0;
          nxt_e.shreg = byte_in;
          nxt_e.bits = e_ff.bits + 1'b1;
          if (e_ff.bits == 3'h7 && e_ff.st == RX_CMD)
          begin
            nxt_e.addr = byte_in[6:0];
            nxt_e.st = byte_in[gauge_pkg::CMD_WRITE_BIT] ? RX_DATA : TURN;
          end
          else if (e_ff.bits == 3'h7)
          begin
            nxt_e.wr_stb = 1'b1;
            nxt_e.st = RX_CMD;
          end
        end
        else if (e_ff.cnt == CW'(IDLE_CYCLES))
        begin
          // Idle line abandons a partial byte
          nxt_e.bits = '0;
          nxt_e.st = RX_CMD;
        end
        else
        begin
          nxt_e.cnt = e_ff.cnt + 1'b1;
        end
      end
      TURN:
      begin
        nxt_e.cnt = e_ff.cnt + 1'b1;
        if (e_ff.cnt == CW'(TURN_CYCLES - 1))
        begin
          nxt_e.shreg = rd_data;
          nxt_e.cnt = '0;
          nxt_e.bits = '0;
          nxt_e.oe_n = 1'b0;
          nxt_e.st = TX_LOW;
        end
      end
      TX_LOW:
      begin
        nxt_e.cnt = e_ff.cnt + 1'b1;
        if (e_ff.cnt == (e_ff.shreg[0] ? CW'(SHORT_CYCLES - 1)
                                       : CW'(LONG_CYCLES - 1)))
        begin
          nxt_e.oe_n = 1'b1;
          nxt_e.st = TX_HIGH;
        end
      end
      TX_HIGH:
      begin
        nxt_e.cnt = e_ff.cnt + 1'b1;
        if (e_ff.cnt == CW'(BIT_CYCLES - 1))
        begin
          nxt_e.cnt = '0;
          nxt_e.shreg = {1'b0, e_ff.shreg[7:1]};
          nxt_e.bits = e_ff.bits + 1'b1;
          nxt_e.low = 1'b0;
          nxt_e.oe_n = (e_ff.bits == 3'h7);
          nxt_e.st = (e_ff.bits == 3'h7) ? RX_CMD : TX_LOW;
        end
      end
      default:
      begin
        nxt_e.st = RX_CMD;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      e_ff <= '0;
      e_ff.oe_n <= 1'b1;
    end
    else if (ce)
    begin
      e_ff <= nxt_e;
    end
  end
endmodule
